// file: rtl/adcpr_pin_sync.sv
`timescale 1ns/10ps
module adcpr_pin_sync #(
  parameter int         W       = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // pins
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  wire  [W-1:0] agree = ~(s2_q ^ s3_q);
  // a bit moves only once the second and third stages agree
  wire  [W-1:0] level_d = (agree & s2_q) | (~agree & level_out);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q      <= RST_VAL;
      s2_q      <= RST_VAL;
      s3_q      <= RST_VAL;
      level_out <= RST_VAL;
    end else begin
      s1_q      <= pin_in;
      s2_q      <= s1_q;
      s3_q      <= s2_q;
      level_out <= level_d;
    end
  end
endmodule

// file: rtl/adcpr_pkg.sv
package adcpr_pkg;
  // selector codes
  localparam logic [1:0]  SEL_RESULT   = 2'h0;
  localparam logic [1:0]  SEL_CONFIG   = 2'h1;
  localparam logic [1:0]  SEL_LOW      = 2'h2;
  localparam logic [1:0]  SEL_HIGH     = 2'h3;
  localparam int          SEL_W        = 2;
  // target address: upper five bits fixed, lower two from the offset pins
  localparam logic [6:0]  BASE_ADDR    = 7'h48;
  // reset values
  localparam logic [15:0] RESULT_RST   = 16'h0000;
  localparam logic [15:0] CONFIG_RST   = 16'h8583;
  localparam logic [15:0] LOW_RST      = 16'h8000;
  localparam logic [15:0] HIGH_RST     = 16'h7fff;
  localparam logic [7:0]  PTR_RST      = 8'h00;
  // saturation codes
  localparam logic [15:0] RESULT_MAX   = 16'h7fff;
  localparam logic [15:0] RESULT_MIN   = 16'h8000;
  // configuration field positions
  localparam int          CFG_START    = 15;
  localparam int          CFG_MUX_LSB  = 12;
  localparam int          CFG_GAIN_LSB = 9;
  localparam int          CFG_MODE     = 8;
  localparam int          CFG_RATE_LSB = 5;
  localparam int          CFG_CTYPE    = 4;
  localparam int          CFG_POL      = 3;
  localparam int          CFG_LATCH    = 2;
  localparam int          CFG_QUE_LSB  = 0;
  // byte position within a transfer
  localparam logic [1:0]  BYTE_ADDR    = 2'h0;
  localparam logic [1:0]  BYTE_PTR     = 2'h1;
  localparam logic [1:0]  BYTE_MSB     = 2'h2;
  localparam logic [1:0]  BYTE_LSB     = 2'h3;
  localparam logic [3:0]  BITS_BYTE    = 4'h8;
  localparam logic [3:0]  TX_LAST_BIT  = 4'h7;
  // pin synchroniser reset: {addr1, addr0, sda, scl}
  localparam logic [3:0]  PIN_RST      = 4'h3;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_RACK
  } adcpr_state_type;
endpackage

// file: rtl/adcpr_reg_if.sv
`timescale 1ns/10ps
interface adcpr_reg_if;
  logic        ptr_stb;
  logic [7:0]  ptr_byte;
  logic        wr_stb;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  modport link (output ptr_stb, output ptr_byte, output wr_stb, output wr_data,
                input rd_data);
  modport regs (input ptr_stb, input ptr_byte, input wr_stb, input wr_data,
                output rd_data);
endinterface

// file: rtl/adcpr_regs.sv
`timescale 1ns/10ps
module adcpr_regs
  import adcpr_pkg::*;
#(
  parameter bit HAS_MUX  = 1'b1,
  parameter bit HAS_GAIN = 1'b1,
  parameter bit HAS_COMP = 1'b1,
  parameter int RAW_W    = 18
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // link side
  adcpr_reg_if.regs             bus,
  // converter
  input  wire logic             conv_busy_in,
  input  wire logic             conv_done_in,
  input  wire logic [RAW_W-1:0] conv_value_in,
  output logic                  conv_start_out,
  // configuration
  output logic      [15:0]      config_out,
  output logic      [15:0]      low_limit_out,
  output logic      [15:0]      high_limit_out
);
  localparam logic [15:0] CFG_MASK = {1'b0, {3{HAS_MUX}}, {3{HAS_GAIN}}, 4'hf, {5{HAS_COMP}}};

  logic [SEL_W-1:0] sel_q;
  logic [15:0]      result_q;

  function automatic logic hit(input logic [SEL_W-1:0] s, input logic [SEL_W-1:0] code);
    hit = (s == code);
  endfunction

  wire        wr_cfg   = bus.wr_stb & hit(sel_q, SEL_CONFIG);
  wire        wr_low   = bus.wr_stb & hit(sel_q, SEL_LOW) & HAS_COMP;
  wire        wr_high  = bus.wr_stb & hit(sel_q, SEL_HIGH) & HAS_COMP;
  // absent fields keep their reset pattern whatever is written
  wire [15:0] cfg_d    = (bus.wr_data & CFG_MASK) | (CONFIG_RST & ~CFG_MASK);
  wire        pwr_down = config_out[CFG_MODE] & ~conv_busy_in;
  wire        start_d  = wr_cfg & bus.wr_data[CFG_START] & pwr_down;
  wire        too_hi   = ~conv_value_in[RAW_W-1] & (|conv_value_in[RAW_W-2:15]);
  wire        too_lo   = conv_value_in[RAW_W-1] & ~(&conv_value_in[RAW_W-2:15]);
  wire [15:0] clipped  = too_hi ? RESULT_MAX : too_lo ? RESULT_MIN
                       : conv_value_in[15:0];
  wire [15:0] cfg_rd   = {~conv_busy_in, config_out[14:0]};
  wire [15:0] low_rd   = HAS_COMP ? low_limit_out : 16'h0000;
  wire [15:0] high_rd  = HAS_COMP ? high_limit_out : 16'h0000;

  always_comb begin
    unique case (sel_q)
      SEL_RESULT: bus.rd_data = result_q;
      SEL_CONFIG: bus.rd_data = cfg_rd;
      SEL_LOW:    bus.rd_data = low_rd;
      SEL_HIGH:   bus.rd_data = high_rd;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sel_q          <= PTR_RST[SEL_W-1:0];
      result_q       <= RESULT_RST;
      config_out     <= CONFIG_RST;
      low_limit_out  <= LOW_RST;
      high_limit_out <= HIGH_RST;
      conv_start_out <= 1'b0;
    end else begin
      // selector survives across transfers until the next pointer byte
      if (bus.ptr_stb) sel_q <= bus.ptr_byte[SEL_W-1:0];
      if (conv_done_in) result_q <= clipped;
      if (wr_cfg) config_out <= cfg_d;
      if (wr_low) low_limit_out <= bus.wr_data;
      if (wr_high) high_limit_out <= bus.wr_data;
      conv_start_out <= start_d;
    end
  end
  // a pair aimed at the result register is acknowledged and dropped
endmodule

// file: rtl/adcpr_top.sv
// Overview of operation
// - write transfer: address byte, acknowledge, then pointer byte captured as selector.
// - pointer byte is acknowledged; controller may then STOP or restart.
// - reads return the register picked by the last written selector.
// - selector is kept across transfers until a later write changes it.
// - controller may not-acknowledge after any byte; device releases data line.
// - two low address bits follow the address-select pin.
// - results are 16-bit two's complement.
// - result saturates at 7fff and 8000 beyond full scale.
// - selector 0 result, 1 configuration, 2 low limit, 3 high limit.
// - exactly four data registers, reached only through the write-only pointer.
// - result reads zero from reset until the first conversion; read-only.
// - result register always holds the latest completed conversion.
// - configuration register resets to 8583.
// - configuration fields: start, input, gain, mode, rate, type, polarity, latch, queue.
// - limit registers set comparator limits; absent without comparator.
// - 16-bit values travel most significant byte first, each byte acknowledged.
// - target address is 1001000 plus a two-bit pin offset.
// - start bit written one starts a conversion only when powered down.
`timescale 1ns/10ps
module adcpr_top
  import adcpr_pkg::*;
#(
  parameter bit HAS_MUX  = 1'b1,
  parameter bit HAS_GAIN = 1'b1,
  parameter bit HAS_COMP = 1'b1,
  parameter int RAW_W    = 18
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // serial bus pins
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe_out,
  // address-select pin, already decoded to two levels
  input  wire logic             addr_offset_bit0_in,
  input  wire logic             addr_offset_bit1_in,
  // converter
  input  wire logic             conv_busy_in,
  input  wire logic             conv_done_in,
  input  wire logic [RAW_W-1:0] conv_value_in,
  output logic                  conv_start_out,
  // configuration fields
  output logic      [2:0]       input_select_out,
  output logic      [2:0]       gain_range_out,
  output logic                  single_shot_out,
  output logic      [2:0]       sample_rate_out,
  output logic                  window_mode_out,
  output logic                  alert_polarity_out,
  output logic                  alert_latch_out,
  output logic      [1:0]       alert_queue_out,
  // comparator limits
  output logic      [15:0]      low_limit_out,
  output logic      [15:0]      high_limit_out
);
  adcpr_reg_if reg_bus ();

  logic [3:0]      pins_s;
  logic [15:0]     config_w;
  adcpr_state_type state_q;
  adcpr_state_type state_d;
  logic            scl_prev_q;
  logic            sda_prev_q;
  logic [3:0]      bit_q;
  logic [3:0]      bit_d;
  logic [1:0]      byte_q;
  logic [1:0]      byte_d;
  logic            rd_q;
  logic            rd_d;
  logic [7:0]      shift_q;
  logic [7:0]      shift_d;
  logic [7:0]      hold_q;
  logic [7:0]      hold_d;
  logic [15:0]     tx_q;
  logic [15:0]     tx_d;
  logic            lsb_q;
  logic            lsb_d;
  logic            low_q;
  logic            low_d;
  // one-cycle strobes towards the register bank
  logic            ptr_stb;
  logic            wr_stb;

  // the data line moves about five clocks after a fall of the serial clock
  // pin, so that clock must stay low for at least six clocks; a faster
  // controller would see data change while its clock is high
  adcpr_pin_sync #(
    .W       (4),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    ({addr_offset_bit1_in, addr_offset_bit0_in, sda_in, scl_in}),
    .level_out (pins_s)
  );

  adcpr_regs #(
    .HAS_MUX  (HAS_MUX),
    .HAS_GAIN (HAS_GAIN),
    .HAS_COMP (HAS_COMP),
    .RAW_W    (RAW_W)
  ) u_regs (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .bus            (reg_bus.regs),
    .conv_busy_in   (conv_busy_in),
    .conv_done_in   (conv_done_in),
    .conv_value_in  (conv_value_in),
    .conv_start_out (conv_start_out),
    .config_out     (config_w),
    .low_limit_out  (low_limit_out),
    .high_limit_out (high_limit_out)
  );

  // bus events from the filtered pin levels
  wire       scl_s    = pins_s[0];
  wire       sda_s    = pins_s[1];
  wire [1:0] offset_s = pins_s[3:2];
  wire       scl_rise = scl_s & ~scl_prev_q;
  wire       scl_fall = ~scl_s & scl_prev_q;
  wire       start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire       stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  // offset pins are watched continuously, not latched at reset
  wire [6:0] own_addr = {BASE_ADDR[6:2], offset_s};
  wire       addr_hit = (shift_q[7:1] == own_addr);
  wire       byte_end = scl_fall & (bit_q == BITS_BYTE);
  // after the lsb, a further acknowledged byte restarts from a fresh msb
  wire [15:0] next_tx = lsb_q ? reg_bus.rd_data : tx_q;
  // byte engine helpers
  wire        take_bit  = scl_rise & (bit_q != BITS_BYTE);
  wire [3:0]  bit_next  = bit_q + 4'h1;
  wire [7:0]  shift_nx  = {shift_q[6:0], sda_s};
  wire        is_read   = shift_q[0];
  wire        tx_last   = (bit_q == TX_LAST_BIT);
  wire [15:0] tx_shift  = {tx_q[14:0], 1'b0};
  wire        tx_low_nx = ~tx_q[14];
  wire        ctrl_nack = scl_rise & sda_s;
  wire        rd_low    = ~reg_bus.rd_data[15];
  wire        nx_low    = ~next_tx[15];

  assign reg_bus.ptr_stb  = ptr_stb;
  assign reg_bus.ptr_byte = shift_q;
  assign reg_bus.wr_stb   = wr_stb;
  assign reg_bus.wr_data  = {hold_q, shift_q};

  // open-drain: only ever pulls low
  assign sda_out    = 1'b0;
  assign sda_oe_out = low_q;

  // configuration fields straight from the register bank
  assign input_select_out   = config_w[CFG_MUX_LSB +: 3];
  assign gain_range_out     = config_w[CFG_GAIN_LSB +: 3];
  assign single_shot_out    = config_w[CFG_MODE];
  assign sample_rate_out    = config_w[CFG_RATE_LSB +: 3];
  assign window_mode_out    = config_w[CFG_CTYPE];
  assign alert_polarity_out = config_w[CFG_POL];
  assign alert_latch_out    = config_w[CFG_LATCH];
  assign alert_queue_out    = config_w[CFG_QUE_LSB +: 2];

  always_comb begin
    state_d = state_q;
    bit_d   = bit_q;
    byte_d  = byte_q;
    rd_d    = rd_q;
    shift_d = shift_q;
    hold_d  = hold_q;
    tx_d    = tx_q;
    lsb_d   = lsb_q;
    low_d   = low_q;
    ptr_stb = 1'b0;
    wr_stb  = 1'b0;
    if (stop_ev) begin
      // a stop anywhere drops the transfer; the selector is kept
      state_d = ST_IDLE;
      low_d   = 1'b0;
    end else if (start_ev) begin
      // repeated start is handled like a fresh one
      state_d = ST_RX;
      bit_d   = 4'h0;
      byte_d  = BYTE_ADDR;
      low_d   = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // only a start wakes the engine
          low_d = 1'b0;
        end
        ST_RX: begin
          if (take_bit) begin
            shift_d = shift_nx;
            bit_d   = bit_next;
          end
          if (byte_end) begin
            state_d = ST_ACK;
            low_d   = 1'b1;
            unique case (byte_q)
              BYTE_ADDR: begin
                if (addr_hit) begin
                  rd_d   = is_read;
                  byte_d = BYTE_PTR;
                end else begin
                  // not ours: stay off the line until the next start
                  state_d = ST_IDLE;
                  low_d   = 1'b0;
                end
              end
              BYTE_PTR: begin
                // upper pointer bits are ignored
                ptr_stb = 1'b1;
                byte_d  = BYTE_MSB;
              end
              BYTE_MSB: begin
                hold_d = shift_q;
                byte_d = BYTE_LSB;
              end
              BYTE_LSB: begin
                // the pair commits here; a lone trailing byte never gets this far
                wr_stb = 1'b1;
                byte_d = BYTE_MSB;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_d = 4'h0;
            if (rd_q) begin
              // snapshot the selected register so both bytes belong together
              state_d = ST_TX;
              tx_d    = reg_bus.rd_data;
              lsb_d   = 1'b0;
              low_d   = rd_low;
            end else begin
              state_d = ST_RX;
              low_d   = 1'b0;
            end
          end
        end
        ST_TX: begin
          // the msb left at the acknowledge fall; seven more falls send the rest and the eighth ends the byte
          if (scl_fall) begin
            tx_d = tx_shift;
            if (tx_last) begin
              state_d = ST_RACK;
              low_d   = 1'b0;
            end else begin
              bit_d = bit_next;
              low_d = tx_low_nx;
            end
          end
        end
        ST_RACK: begin
          // the controller's acknowledge is read on the rise
          if (ctrl_nack) begin
            state_d = ST_IDLE;
            low_d   = 1'b0;
          end else if (scl_fall) begin
            state_d = ST_TX;
            bit_d   = 4'h0;
            tx_d    = next_tx;
            lsb_d   = ~lsb_q;
            low_d   = nx_low;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q    <= ST_IDLE;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      bit_q      <= 4'h0;
      byte_q     <= BYTE_ADDR;
      rd_q       <= 1'b0;
      shift_q    <= 8'h00;
      hold_q     <= 8'h00;
      tx_q       <= 16'h0000;
      lsb_q      <= 1'b0;
      low_q      <= 1'b0;
    end else begin
      state_q    <= state_d;
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      bit_q      <= bit_d;
      byte_q     <= byte_d;
      rd_q       <= rd_d;
      shift_q    <= shift_d;
      hold_q     <= hold_d;
      tx_q       <= tx_d;
      lsb_q      <= lsb_d;
      low_q      <= low_d;
    end
  end
endmodule

// file: tb/adcpr_i2c_ctrl.sv
`timescale 1ns/10ps
module adcpr_i2c_ctrl (
  // clock
  input  wire logic       clk_in,
  // bus lines
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            sda_low_out,
  // what the controller saw
  output logic            ack_tgl_out,
  output logic            ack_low_out,
  output logic            rx_tgl_out,
  output logic      [7:0] rx_byte_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    ack_tgl_out = 1'b0;
    ack_low_out = 1'b0;
    rx_tgl_out = 1'b0;
    rx_byte_out = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // eight clocks a bit, six of them low: the target moves the data line
  // about five clocks after the clock pin falls
  task automatic bit_cycle(input logic pull, output logic seen);
    tick(2);
    sda_low_out = pull;
    tick(4);
    scl_out = 1'b1;
    tick(1);
    seen = sda_in;
    tick(1);
    scl_out = 1'b0;
  endtask
  // from idle, or as a repeated start from a low clock
  task automatic start();
    if (!scl_out) begin
      tick(2);
      sda_low_out = 1'b0;
      tick(4);
      scl_out = 1'b1;
      tick(4);
    end
    sda_low_out = 1'b1;
    tick(4);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_low_out = 1'b1;
    tick(4);
    scl_out = 1'b1;
    tick(4);
    sda_low_out = 1'b0;
    tick(8);
  endtask
  task automatic wr_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(~b[i], s);
    bit_cycle(1'b0, s);
    ack_low_out = ~s;
    ack_tgl_out = ~ack_tgl_out;
  endtask
  task automatic rd_byte(input logic nack);
    logic [7:0] v;
    logic       s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b0, s);
      v[i] = s;
    end
    bit_cycle(~nack, s);
    rx_byte_out = v;
    rx_tgl_out = ~rx_tgl_out;
  endtask
endmodule

// file: tb/adcpr_top_properties.sv
`timescale 1ns/10ps
module adcpr_top_props (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  // serial pins
  input wire logic        scl_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_out,
  // converter
  input wire logic        conv_busy_in,
  input wire logic        conv_start_out,
  input wire logic        single_shot_out,
  // registers
  input wire logic [2:0]  sample_rate_out,
  input wire logic [15:0] low_limit_out,
  input wire logic [15:0] high_limit_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  a_start_one_cycle: assert property (conv_start_out |=> !conv_start_out)
    else $error("start pulse too long");
  a_start_not_busy: assert property (conv_start_out |-> !$past(conv_busy_in))
    else $error("start while converting");
  a_start_single_shot: assert property (conv_start_out |-> $past(single_shot_out))
    else $error("start outside power-down");
  a_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_pull_clock_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data line moved while clock high");
  a_idle_released: assert property (scl_in [*8] |-> !sda_oe_out)
    else $error("data held with clock idle");
  // register writes commit only at a byte boundary, just after a clock fall
  a_cfg_on_write: assert property (
    $changed({single_shot_out, sample_rate_out}) |-> !$past(scl_in, 4))
    else $error("config changed off a byte end");
  a_low_on_write: assert property ($changed(low_limit_out) |-> !$past(scl_in, 4))
    else $error("low limit changed off a byte end");
  a_high_on_write: assert property ($changed(high_limit_out) |-> !$past(scl_in, 4))
    else $error("high limit changed off a byte end");
endmodule
bind adcpr_top adcpr_top_props props_u (
  .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .conv_busy_in(conv_busy_in), .conv_start_out(conv_start_out),
  .single_shot_out(single_shot_out), .sample_rate_out(sample_rate_out),
  .low_limit_out(low_limit_out), .high_limit_out(high_limit_out));

// file: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import adcpr_pkg::*;
  logic        clk_in;
  logic        rst_in;
  logic [1:0]  offs;
  logic        busy;
  logic        done;
  logic [17:0] value;
  logic [15:0] w;
  logic [17:0] v;
  logic [6:0]  dev_addr;
  logic [31:0] rng = 32'h0000_5dd4;
  logic        rx_seen = 1'b0;
  logic        ack_seen = 1'b0;
  logic [7:0]  exp_byte[$];
  logic        exp_ack[$];
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          n_starts = 0;
  int          n;
  wire logic   scl;
  wire logic   sda_low;
  wire logic   oe;
  wire logic   start_p;
  wire logic   ack_tgl;
  wire logic   ack_low;
  wire logic   rx_tgl;
  wire logic [7:0]  rx_byte;
  wire logic [14:0] cfg_seen;
  wire logic [15:0] low_lim;
  wire logic [15:0] high_lim;
  wire logic   sda_wire;
  logic [17:0] conv_tab [4] = '{18'h1_0000, 18'h2_0000, 18'h0_7fff, 18'h3_8000};
  // pull-up: low whenever either side pulls
  assign sda_wire = ~(oe | sda_low);
  adcpr_top dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_wire), .sda_out(),
    .sda_oe_out(oe), .addr_offset_bit0_in(offs[0]), .addr_offset_bit1_in(offs[1]),
    .conv_busy_in(busy), .conv_done_in(done), .conv_value_in(value),
    .conv_start_out(start_p), .input_select_out(cfg_seen[14:12]),
    .gain_range_out(cfg_seen[11:9]), .single_shot_out(cfg_seen[8]),
    .sample_rate_out(cfg_seen[7:5]), .window_mode_out(cfg_seen[4]),
    .alert_polarity_out(cfg_seen[3]), .alert_latch_out(cfg_seen[2]),
    .alert_queue_out(cfg_seen[1:0]), .low_limit_out(low_lim), .high_limit_out(high_lim));
  adcpr_i2c_ctrl ctrl_u (
    .clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl), .sda_low_out(sda_low),
    .ack_tgl_out(ack_tgl), .ack_low_out(ack_low), .rx_tgl_out(rx_tgl), .rx_byte_out(rx_byte));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  function automatic logic [15:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[15:0];
  endfunction
  function automatic logic [15:0] sat(input logic [17:0] x);
    if ($signed(x) > 18'sh0_7fff)
      return RESULT_MAX;
    if ($signed(x) < -18'sh0_8000)
      return RESULT_MIN;
    return x[15:0];
  endfunction
  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    check_val("pending notes", 16'h0000, 16'(exp_byte.size() + exp_ack.size()));
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic send(input logic [7:0] b, input logic acked);
    exp_ack.push_back(acked);
    ctrl_u.wr_byte(b);
  endtask
  task automatic set_ptr(input logic [1:0] sel, input bit with_stop);
    ctrl_u.start();
    send({dev_addr, 1'b0}, 1'b1);
    send({6'h00, sel}, 1'b1);
    if (with_stop)
      ctrl_u.stop();
  endtask
  task automatic reg_write(input logic [1:0] sel, input logic [15:0] d);
    set_ptr(sel, 1'b0);
    send(d[15:8], 1'b1);
    send(d[7:0], 1'b1);
    ctrl_u.stop();
  endtask
  task automatic reg_read(input logic [15:0] exp, input bit two);
    ctrl_u.start();
    send({dev_addr, 1'b1}, 1'b1);
    exp_byte.push_back(exp[15:8]);
    ctrl_u.rd_byte(~two);
    if (two) begin
      exp_byte.push_back(exp[7:0]);
      ctrl_u.rd_byte(1'b1);
    end
    ctrl_u.stop();
  endtask
  task automatic conv_pulse(input logic [17:0] x);
    done = 1'b1;
    value = x;
    @(negedge clk_in);
    done = 1'b0;
    value = 18'(rnd());
  endtask
  always @(posedge clk_in) begin
    if (start_p === 1'b1)
      n_starts++;
    if (rx_tgl !== rx_seen) begin
      rx_seen = rx_tgl;
      check_val("read byte", {8'h00, exp_byte.pop_front()}, {8'h00, rx_byte});
    end
    if (ack_tgl !== ack_seen) begin
      ack_seen = ack_tgl;
      check_val("ack", {15'h0000, exp_ack.pop_front()}, {15'h0000, ack_low});
    end
  end
  initial begin
    repeat (80000) @(posedge clk_in);
    n_mismatch++;
    finish_test();
  end
  initial begin
    rst_in = 1'b1;
    offs = 2'b00;
    busy = 1'b0;
    done = 1'b0;
    value = 18'h0_0000;
    dev_addr = BASE_ADDR;
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (8) @(negedge clk_in);
    check_val("config reset", {1'b0, CONFIG_RST[14:0]}, {1'b0, cfg_seen});
    check_val("low reset", LOW_RST, low_lim);
    check_val("high reset", HIGH_RST, high_lim);
    reg_read(RESULT_RST, 1'b1);
    set_ptr(SEL_CONFIG, 1'b1);
    reg_read(CONFIG_RST, 1'b1);
    w = rnd() & 16'h7eff;
    reg_write(SEL_CONFIG, w);
    check_val("config fields", {1'b0, w[14:0]}, {1'b0, cfg_seen});
    reg_read({1'b1, w[14:0]}, 1'b1);
    n = n_starts;
    reg_write(SEL_CONFIG, 16'h0583);
    reg_write(SEL_CONFIG, 16'h8583);
    busy = 1'b1;
    reg_write(SEL_CONFIG, 16'h8583);
    reg_read(16'h0583, 1'b0);
    busy = 1'b0;
    check_val("start requests", 16'h0001, 16'(n_starts - n));
    for (int s = 2; s < 4; s++) begin
      w = rnd();
      reg_write(2'(s), w);
      check_val("limit", w, (s == 2) ? low_lim : high_lim);
      reg_read(w, 1'b1);
      reg_read(w, 1'b1);
    end
    set_ptr(SEL_RESULT, 1'b0);
    for (int k = 0; k < 6; k++) begin
      v = (k < 4) ? conv_tab[k] : 18'(rnd());
      conv_pulse(v);
      reg_read(sat(v), 1'b1);
    end
    reg_write(SEL_RESULT, ~sat(v));
    reg_read(sat(v), 1'b1);
    for (int k = 0; k < 4; k++) begin
      offs = 2'(k);
      dev_addr = BASE_ADDR | 7'(k);
      repeat (8) @(negedge clk_in);
      ctrl_u.start();
      send({dev_addr ^ 7'h01, 1'b0}, 1'b0);
      ctrl_u.stop();
      set_ptr(SEL_CONFIG, 1'b0);
      reg_read(16'h8583, 1'b1);
    end
    finish_test();
  end
endmodule
